// file: pkg/rmw_pkg.sv
package rmw_pkg;

	// ----------------------------------------------------------------
	// Register map, byte addresses on the Wishbone slave
	// ----------------------------------------------------------------
	localparam int unsigned WB_ADDR_W   = 6;
	localparam logic [5:0] OFS_CTRL     = 6'h00;
	localparam logic [5:0] OFS_ZOOM     = 6'h04;
	localparam logic [5:0] OFS_ADDR     = 6'h08;
	localparam logic [5:0] OFS_PATTERN  = 6'h0c;
	localparam logic [5:0] OFS_MASK     = 6'h10;
	localparam logic [5:0] OFS_PIXIDX   = 6'h14;
	localparam logic [5:0] OFS_COUNT    = 6'h18;
	localparam logic [5:0] OFS_STATUS   = 6'h1c;
	localparam logic [5:0] OFS_RDATA    = 6'h20;

	// ----------------------------------------------------------------
	// Control and status register fields
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_OP_LSB   = 2;
	localparam int unsigned CTRL_FIG_BIT  = 4;
	localparam int unsigned CTRL_DIR_BIT  = 5;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_PTR_LSB  = 4;
	localparam int unsigned STAT_LEFT_LSB = 16;

	// ----------------------------------------------------------------
	// Memory cycle timing, counted in half phases of the word clock
	// ----------------------------------------------------------------
	localparam logic [5:0] HALF_PER_PHASE = 6'h02;
	localparam logic [5:0] H_ADDR_END     = 6'h02;
	localparam logic [5:0] H_RDE_FIRST    = 6'h03;
	localparam logic [5:0] H_SAMPLE       = 6'h04;
	localparam logic [5:0] H_WB_FIRST     = 6'h06;
	localparam logic [5:0] H_BASIC_END    = 6'h08;
	localparam logic [3:0] ZOOM_STRETCH   = 4'h3;
	localparam logic [15:0] CHAR_BITS_MASK = 16'h1fff;

	typedef enum logic [1:0] {
		MODE_GRAPHICS = 2'b00,
		MODE_CHAR     = 2'b01,
		MODE_MIXED    = 2'b10
	} rmw_mode_e;

	typedef enum logic [1:0] {
		OP_REPLACE    = 2'b00,
		OP_COMPLEMENT = 2'b01,
		OP_CLEAR      = 2'b10,
		OP_SET        = 2'b11
	} rmw_op_e;

	typedef enum logic [0:0] {
		CYC_DISPLAY = 1'b0,
		CYC_RMW     = 1'b1
	} rmw_cyc_e;

	typedef struct packed {
		logic [15:0] ad_out;
		logic        ad_oe;
		logic [1:0]  addr_hi;
		logic        ale;
		logic        read_data_enable_n;
		logic        blank;
	} rmw_mem_s;

	localparam rmw_mem_s MEM_RESET = '{ad_out: 16'h0000, ad_oe: 1'b0, addr_hi: 2'h0, ale: 1'b0,
		read_data_enable_n: 1'b1, blank: 1'b0};

endpackage

// file: hw/rmw_logic_unit.sv
`timescale 1ns/1ps
module rmw_logic_unit (
	input  wire logic [15:0]          read_word_i,
	input  wire logic [15:0]          pattern_i,
	input  wire logic [15:0]          mask_i,
	input  wire logic [3:0]           pattern_ptr_i,
	input  wire rmw_pkg::rmw_op_e     op_i,
	input  wire rmw_pkg::rmw_mode_e   mode_i,
	input  wire logic                 figure_i,
	output logic [15:0]               write_word_o
);
	import rmw_pkg::*;

	logic [15:0] pat;
	logic [15:0] msk;

	// Figure drawing spreads the selected pattern bit to every lane; word writes spread pattern bit 0 in graphics mode, else use the whole pattern.
	always_comb begin
		if (figure_i) begin
			pat = {16{pattern_i[pattern_ptr_i]}};
		end else if (mode_i == MODE_GRAPHICS) begin
			pat = {16{pattern_i[0]}};
		end else begin
			pat = pattern_i;
		end
		msk = (mode_i == MODE_CHAR) ? (mask_i & CHAR_BITS_MASK) : mask_i;
	end

	genvar b;
	generate
		for (b = 0; b < 16; b++) begin : g_bit
			always_comb begin
				write_word_o[b] = read_word_i[b];
				case (op_i)
					OP_REPLACE: begin
						if (msk[b]) begin
							write_word_o[b] = pat[b];
						end
					end
					OP_COMPLEMENT: begin
						if (msk[b] && pat[b]) begin
							write_word_o[b] = ~read_word_i[b];
						end
					end
					OP_CLEAR: begin
						if (msk[b] && pat[b]) begin
							write_word_o[b] = 1'b0;
						end
					end
					OP_SET: begin
						if (msk[b] && pat[b]) begin
							write_word_o[b] = 1'b1;
						end
					end
					default: begin
						write_word_o[b] = read_word_i[b];
					end
				endcase
			end
		end
	endgenerate

endmodule

// file: hw/rmw_cycle_engine.sv
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Every transfer to display memory runs as a read-modify-write cycle, never a display fetch.
// - A basic cycle lasts four word clock phases while zoom is two or less.
// - A started cycle always completes and starts only at a display cycle boundary.
// - Write-back always happens; unmodified bits echo exactly what was read.
// - Phase one drives the address and drops the latch strobe at mid-phase.
// - Read enable falls after mid phase two, rises after mid phase three; sample mid three.
// - Modified word is driven from start of phase four through its end.
// - Latch strobe stays low through phase four; extra shift register loads are harmless.
// - Video is blanked for the full length of each read-modify-write cycle.
// - Zoom three or more stretches the cycle with the strobe high to display length.
// - Figure drawing reads the word at the execution address and alters one selected bit.
// - Character mode changes any of 13 bits, mixed mode any of 16.
// - Pattern pointer walks low to high; a one enables the operation, zero leaves bit, except replace writes the zero.
// - In mixed mode word writes store the pattern register as 16-bit words.
// - The one-hot mask marks the changed bit and shifts as drawing steps.
// - The logic unit combines read word, pattern and mask into the written word.
// - Drawing logic steps the address and steers pattern and mask bit selection.
// - One display cycle is one pair of word clock cycles per zoom step, each two half phases here.
module rmw_cycle_engine (
	input  wire logic              ref_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [5:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic [15:0]       ad_i,
	output rmw_pkg::rmw_mem_s      mem_o
);
	import rmw_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		rmw_mem_s    mem;
		rmw_cyc_e    st;
		logic [5:0]  cnt;
		rmw_mode_e   mode;
		rmw_mode_e   cyc_mode;
		rmw_op_e     op;
		logic        figure;
		logic        dir;
		logic [3:0]  zoom;
		logic [17:0] ead;
		logic [17:0] disp_addr;
		logic [15:0] pattern;
		logic [15:0] mask;
		logic [3:0]  ptr;
		logic [15:0] left;
		logic [15:0] rdata;
		logic        ack;
		logic [31:0] dat;
	} rmw_state_s;

	localparam rmw_state_s STATE_RESET = '{mem: MEM_RESET, st: CYC_DISPLAY, cnt: 6'h00, mode: MODE_GRAPHICS,
		cyc_mode: MODE_GRAPHICS, op: OP_REPLACE, figure: 1'b0, dir: 1'b0, zoom: 4'h1, ead: 18'h00000,
		disp_addr: 18'h00000, pattern: 16'h0000, mask: 16'h0001, ptr: 4'h0, left: 16'h0000,
		rdata: 16'h0000, ack: 1'b0, dat: 32'h00000000};

	rmw_state_s  state_reg;
	rmw_state_s  state_next;
	logic [15:0] write_word;

	rmw_logic_unit u_logic (
		.read_word_i   (state_reg.rdata),
		.pattern_i     (state_reg.pattern),
		.mask_i        (state_reg.mask),
		.pattern_ptr_i (state_reg.ptr),
		.op_i          (state_reg.op),
		.mode_i        (state_reg.cyc_mode),
		.figure_i      (state_reg.figure),
		.write_word_o  (write_word)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// A zoom of zero is treated as one so the display cycle never collapses.
	function automatic logic [5:0] disp_len(input logic [3:0] zoom);
		logic [5:0] z;
		z = (zoom == 4'h0) ? 6'h01 : {2'b00, zoom};
		return 6'((z * HALF_PER_PHASE) * 6'h02);
	endfunction

	function automatic logic [5:0] rmw_len(input logic [3:0] zoom);
		logic [5:0] r;
		r = H_BASIC_END;
		if (zoom >= ZOOM_STRETCH) begin
			r = disp_len(zoom);
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        cyc_end;
		logic        wb_req;
		logic [31:0] rd_v;
		logic [31:0] wr_v;
		logic        is_rmw;
		cyc_end = 1'b0;
		wb_req = 1'b0;
		rd_v = 32'h00000000;
		wr_v = 32'h00000000;
		is_rmw = 1'b0;
		state_next = state_reg;

		// Cycle sequencing: a cycle always runs to its last half phase before the next is chosen.
		// A zoom lowered past the current half phase ends the cycle at once instead of letting the counter wrap.
		if (state_reg.st == CYC_RMW) begin
			cyc_end = (state_reg.cnt >= rmw_len(state_reg.zoom) - 6'h01);
		end else begin
			cyc_end = (state_reg.cnt >= disp_len(state_reg.zoom) - 6'h01);
		end

		if (state_reg.st == CYC_RMW && state_reg.cnt == H_SAMPLE) begin
			state_next.rdata = ad_i;
		end

		if (cyc_end) begin
			state_next.cnt = 6'h00;
			if (state_reg.st == CYC_RMW) begin
				if (state_reg.figure) begin
					state_next.ptr = state_reg.ptr + 4'h1;
					if (!state_reg.dir) begin
						state_next.mask = {state_reg.mask[14:0], state_reg.mask[15]};
						if (state_reg.mask[15]) begin
							state_next.ead = state_reg.ead + 18'h00001;
						end
					end else begin
						state_next.mask = {state_reg.mask[0], state_reg.mask[15:1]};
						if (state_reg.mask[0]) begin
							state_next.ead = state_reg.ead - 18'h00001;
						end
					end
				end else begin
					state_next.ead = state_reg.ead + 18'h00001;
				end
			end else begin
				state_next.disp_addr = state_reg.disp_addr + 18'h00001;
			end
			if (state_reg.left != 16'h0000) begin
				state_next.st = CYC_RMW;
				state_next.left = state_reg.left - 16'h0001;
				state_next.cyc_mode = state_reg.mode;
			end else begin
				state_next.st = CYC_DISPLAY;
			end
		end else begin
			state_next.cnt = state_reg.cnt + 6'h01;
		end

		// Pin outputs are formed from the upcoming half phase so that they leave flip-flops.
		is_rmw = (state_next.st == CYC_RMW);
		state_next.mem.ale = (state_next.cnt == 6'h00) || (is_rmw && state_next.cnt >= H_BASIC_END);
		state_next.mem.read_data_enable_n = !(is_rmw && (state_next.cnt == H_RDE_FIRST ||
			state_next.cnt == H_SAMPLE));
		state_next.mem.blank = is_rmw;
		if (state_next.cnt < H_ADDR_END) begin
			state_next.mem.ad_oe = 1'b1;
			state_next.mem.ad_out = is_rmw ? state_next.ead[15:0] : state_next.disp_addr[15:0];
			state_next.mem.addr_hi = is_rmw ? state_next.ead[17:16] : state_next.disp_addr[17:16];
		end else if (is_rmw && state_next.cnt >= H_WB_FIRST && state_next.cnt < H_BASIC_END) begin
			state_next.mem.ad_oe = 1'b1;
			state_next.mem.ad_out = write_word;
		end else begin
			state_next.mem.ad_oe = 1'b0;
		end

		// ------------------------------------------------------------
		// Wishbone slave: ack one cycle after the request, writes land on the ack edge
		// ------------------------------------------------------------
		wb_req = wb_cyc_i && wb_stb_i;
		state_next.ack = wb_req && !state_reg.ack;
		case (wb_adr_i)
			OFS_CTRL: begin
				rd_v = 32'h00000000;
				rd_v[CTRL_MODE_LSB +: 2] = state_reg.mode;
				rd_v[CTRL_OP_LSB +: 2] = state_reg.op;
				rd_v[CTRL_FIG_BIT] = state_reg.figure;
				rd_v[CTRL_DIR_BIT] = state_reg.dir;
			end
			OFS_ZOOM: begin
				rd_v = {28'h0000000, state_reg.zoom};
			end
			OFS_ADDR: begin
				rd_v = {14'h0000, state_reg.ead};
			end
			OFS_PATTERN: begin
				rd_v = {16'h0000, state_reg.pattern};
			end
			OFS_MASK: begin
				rd_v = {16'h0000, state_reg.mask};
			end
			OFS_COUNT: begin
				rd_v = {16'h0000, state_reg.left};
			end
			OFS_STATUS: begin
				rd_v = 32'h00000000;
				rd_v[STAT_BUSY_BIT] = (state_reg.st == CYC_RMW) || (state_reg.left != 16'h0000);
				rd_v[STAT_PTR_LSB +: 4] = state_reg.ptr;
				rd_v[STAT_LEFT_LSB +: 16] = state_reg.left;
			end
			OFS_RDATA: begin
				rd_v = {16'h0000, state_reg.rdata};
			end
			default: begin
				rd_v = 32'h00000000;
			end
		endcase
		if (wb_req && !state_reg.ack) begin
			state_next.dat = wb_we_i ? 32'h00000000 : rd_v;
		end
		if (wb_req && state_reg.ack && wb_we_i) begin
			wr_v = merge_bytes(rd_v, wb_dat_i, wb_sel_i);
			case (wb_adr_i)
				OFS_CTRL: begin
					state_next.mode = rmw_mode_e'(wr_v[CTRL_MODE_LSB +: 2]);
					state_next.op = rmw_op_e'(wr_v[CTRL_OP_LSB +: 2]);
					state_next.figure = wr_v[CTRL_FIG_BIT];
					state_next.dir = wr_v[CTRL_DIR_BIT];
				end
				OFS_ZOOM: begin
					state_next.zoom = wr_v[3:0];
				end
				OFS_ADDR: begin
					state_next.ead = wr_v[17:0];
				end
				OFS_PATTERN: begin
					state_next.pattern = wr_v[15:0];
					state_next.ptr = 4'h0;
				end
				OFS_MASK: begin
					state_next.mask = wr_v[15:0];
				end
				OFS_PIXIDX: begin
					state_next.mask = 16'h0001 << wr_v[3:0];
				end
				OFS_COUNT: begin
					state_next.left = wr_v[15:0];
				end
				default: begin
					state_next.left = state_next.left;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign mem_o = state_reg.mem;
	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = state_reg.dat;

endmodule

// file: test/rmw_monitor.sv
`timescale 1ns/1ps
module rmw_monitor
	import rmw_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              wb_ack_o,
	input  wire rmw_pkg::rmw_mem_s mem_o
);
	// ------------------------------------------------------------
	// Half-phase position inside the current memory cycle
	// ------------------------------------------------------------
	// A cycle starts where the strobe and the address drive are both high.
	logic       st;
	logic [5:0] h;
	logic [5:0] hcnt_reg;
	assign st = mem_o.ale && mem_o.ad_oe;
	assign h = st ? 6'h00 : hcnt_reg;
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hcnt_reg <= 6'h00;
		end else begin
			hcnt_reg <= st ? 6'h01 : ((hcnt_reg == 6'h3f) ? hcnt_reg : hcnt_reg + 6'h01);
		end
	end
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	property p_rise;
		$rose(mem_o.blank) |-> st;
	endproperty
	a_rise: assert property (p_rise) else $error("blank rose away from cycle start");
	property p_bfall;
		$fell(mem_o.blank) |-> st;
	endproperty
	a_bfall: assert property (p_bfall) else $error("blank fell away from cycle start");
	property p_read;
		mem_o.blank && h == 6'h03 |-> !mem_o.read_data_enable_n;
	endproperty
	a_read: assert property (p_read) else $error("transfer cycle without read");
	property p_rde;
		!mem_o.read_data_enable_n |-> mem_o.blank && (h == 6'h03 || h == 6'h04) && !mem_o.ad_oe;
	endproperty
	a_rde: assert property (p_rde) else $error("read enable misplaced");
	property p_pulse;
		$fell(mem_o.read_data_enable_n) |=> !mem_o.read_data_enable_n ##1 mem_o.read_data_enable_n;
	endproperty
	a_pulse: assert property (p_pulse) else $error("read enable width wrong");
	property p_wback;
		mem_o.blank && h == 6'h06 |-> mem_o.ad_oe ##1 (mem_o.ad_oe && $stable(mem_o.ad_out));
	endproperty
	a_wback: assert property (p_wback) else $error("write-back word not held");
	property p_ale;
		mem_o.blank && h >= 6'h01 && h <= 6'h07 |-> !mem_o.ale;
	endproperty
	a_ale: assert property (p_ale) else $error("strobe high inside basic cycle");
	property p_addr;
		st |=> !mem_o.ale && mem_o.ad_oe && $stable(mem_o.ad_out) && $stable(mem_o.addr_hi);
	endproperty
	a_addr: assert property (p_addr) else $error("address phase wrong");
	property p_strch;
		mem_o.blank && h >= 6'h08 |-> mem_o.ale && !mem_o.ad_oe;
	endproperty
	a_strch: assert property (p_strch) else $error("stretch not strobe high");
	property p_len;
		st && $past(mem_o.blank) |-> hcnt_reg == 6'h08 || (hcnt_reg >= 6'h0c && hcnt_reg[1:0] == 2'b00);
	endproperty
	a_len: assert property (p_len) else $error("cycle length wrong");
	c_strch: cover property (mem_o.blank && h == 6'h08);
	c_b2b: cover property (st && $past(mem_o.blank) && mem_o.blank);
	c_ack: cover property (wb_ack_o);
endmodule
bind rmw_cycle_engine rmw_monitor u_mon (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wb_ack_o(wb_ack_o),
	.mem_o(mem_o));

// file: test/rmw_mem_model.sv
`timescale 1ns/1ps
module rmw_mem_model
	import rmw_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              reset_n_i,
	input  wire rmw_pkg::rmw_mem_s mem_i,
	output logic [15:0]            ad_o
);
	// ------------------------------------------------------------
	// Display RAM with simple read-enable timing glue
	// ------------------------------------------------------------
	logic [15:0] mem [256];
	logic [7:0]  adr_reg;
	logic [15:0] last_reg;
	logic        armed_reg;
	logic        wr_reg;
	// A released bus shows the inverse of the last word so stale data never matches.
	assign ad_o = mem_i.read_data_enable_n ? ~last_reg : mem[adr_reg];
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			adr_reg <= 8'h00;
			armed_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else begin
			if (mem_i.ale && mem_i.ad_oe) begin
				adr_reg <= mem_i.ad_out[7:0];
			end
			if (!mem_i.read_data_enable_n) begin
				last_reg <= mem[adr_reg];
				armed_reg <= 1'b1;
			end
			// The write strobe lands in the second half of phase four only.
			if (armed_reg && mem_i.ad_oe && !mem_i.ale) begin
				wr_reg <= !wr_reg;
				if (wr_reg) begin
					mem[adr_reg] <= mem_i.ad_out;
					armed_reg <= 1'b0;
				end
			end
		end
	end
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
	import rmw_pkg::*;
	logic              ref_clk_i = 1'b0;
	logic              reset_n_i = 1'b0;
	logic              cyc = 1'b0;
	logic              stb = 1'b0;
	logic              we = 1'b0;
	logic [5:0]        adr = 6'h00;
	logic [3:0]        sel = 4'h0;
	logic [31:0]       host_write_command = 32'h0;
	logic [31:0]       rdat;
	logic              ack;
	logic [15:0]       ad;
	logic [31:0]       q;
	rmw_mem_s          mem;
	int                error_cnt = 0;
	int                check_count = 0;
	int                cycles = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	rmw_cycle_engine dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(host_write_command), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ad_i(ad), .mem_o(mem));
	rmw_mem_model u_mem (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .mem_i(mem), .ad_o(ad));
	// ------------------------------------------------------------
	// Bus and checking helpers
	// ------------------------------------------------------------
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// No answer time is assumed; only the global cycle ceiling ends a stuck wait.
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		host_write_command <= d;
		sel <= 4'hf;
		do begin
			@(posedge ref_clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic cfg(input logic [31:0] c, input logic [7:0] a, input logic [15:0] p, input logic [15:0] m);
		bus(1'b1, OFS_CTRL, c);
		bus(1'b1, OFS_ADDR, {24'h0, a});
		bus(1'b1, OFS_PATTERN, {16'h0, p});
		bus(1'b1, OFS_MASK, {16'h0, m});
	endtask
	// Busy is polled over the bus; no cycle count is assumed for queued cycles.
	task automatic go(input logic [15:0] cnt);
		int n;
		n = 0;
		bus(1'b1, OFS_COUNT, {16'h0, cnt});
		do begin
			bus(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 100);
		if (q[STAT_BUSY_BIT] !== 1'b0) begin
			error_cnt++;
		end
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		bus(1'b0, OFS_ZOOM, 32'h0);
		chk(q, 32'h1);
		bus(1'b0, OFS_MASK, 32'h0);
		chk(q, 32'h1);
		bus(1'b1, 6'h3c, 32'hffff_ffff);
		bus(1'b0, 6'h3c, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, OFS_STATUS, 32'hffff_ffff);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(q, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_echo;
		u_mem.mem[8'h10] = 16'ha5c3;
		cfg(32'h0, 8'h10, 16'hffff, 16'h0000);
		go(16'h1);
		chk({16'h0, u_mem.mem[8'h10]}, 32'ha5c3);
		bus(1'b0, OFS_RDATA, 32'h0);
		chk(q, 32'ha5c3);
		$display("test echo done");
	endtask
	task automatic t_ops;
		logic [15:0] e;
		for (int op = 0; op < 4; op++) begin
			u_mem.mem[8'h20 + op] = 16'h3c5a;
			cfg({28'h0, op[1:0], 2'b00}, 8'h20 + op[7:0], 16'h0001, 16'h0ff0);
			go(16'h1);
			e = (op == 1) ? 16'h33aa : ((op == 2) ? 16'h300a : 16'h3ffa);
			chk({16'h0, u_mem.mem[8'h20 + op]}, {16'h0, e});
		end
		$display("test ops done");
	endtask
	task automatic t_char;
		u_mem.mem[8'h30] = 16'hffff;
		u_mem.mem[8'h31] = 16'hffff;
		u_mem.mem[8'h32] = 16'hffff;
		cfg(32'h1, 8'h30, 16'h0f0f, 16'hffff);
		go(16'h2);
		chk({16'h0, u_mem.mem[8'h30]}, 32'hef0f);
		chk({16'h0, u_mem.mem[8'h31]}, 32'hef0f);
		cfg(32'h2, 8'h32, 16'h0f0f, 16'hffff);
		go(16'h1);
		chk({16'h0, u_mem.mem[8'h32]}, 32'h0f0f);
		$display("test char done");
	endtask
	task automatic t_fig;
		u_mem.mem[8'h40] = 16'h0000;
		cfg(32'h1c, 8'h40, 16'h0005, 16'h0001);
		bus(1'b1, OFS_PIXIDX, 32'h3);
		go(16'h3);
		chk({16'h0, u_mem.mem[8'h40]}, 32'h0028);
		chk({28'h0, q[7:4]}, 32'h3);
		bus(1'b0, OFS_MASK, 32'h0);
		chk(q, 32'h0040);
		bus(1'b0, OFS_ADDR, 32'h0);
		chk(q, 32'h0040);
		u_mem.mem[8'h60] = 16'h0000;
		u_mem.mem[8'h5f] = 16'h0000;
		cfg(32'h3c, 8'h60, 16'hffff, 16'h0001);
		go(16'h2);
		chk({16'h0, u_mem.mem[8'h60]}, 32'h0001);
		chk({16'h0, u_mem.mem[8'h5f]}, 32'h8000);
		bus(1'b0, OFS_MASK, 32'h0);
		chk(q, 32'h4000);
		bus(1'b0, OFS_ADDR, 32'h0);
		chk(q, 32'h005f);
		$display("test figure done");
	endtask
	task automatic t_zoom;
		bus(1'b1, OFS_ZOOM, 32'h3);
		u_mem.mem[8'h50] = 16'h1234;
		u_mem.mem[8'h51] = 16'h0000;
		cfg(32'hc, 8'h50, 16'h0001, 16'h8001);
		go(16'h2);
		chk({16'h0, u_mem.mem[8'h50]}, 32'h9235);
		chk({16'h0, u_mem.mem[8'h51]}, 32'h8001);
		bus(1'b1, OFS_ZOOM, 32'h1);
		$display("test zoom done");
	endtask
	initial begin
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_echo();
		t_ops();
		t_char();
		t_fig();
		t_zoom();
		end_sim();
	end
endmodule
